/* File: obj_store_consts.vh */
// constants for the object store manager: opcodes, sizes, timing counts
// assumes inclusion by bare name from the design files
`ifndef OBJ_STORE_CONSTS_VH
`define OBJ_STORE_CONSTS_VH

`define OP_SAVE          2'h0
`define OP_DELETE        2'h1
`define OP_FREE          2'h2
`define DESC_CHARS       32
`define DESC_IDX_W       5
`define MAX_OBJECTS      32
`define SLOT_W           5
`define MAX_PROGRAMS     10
`define RAM_BYTES        65536
`define ROM_BYTES        131072
`define ROM_SECTOR_BYTES 65536
`define CLK_MHZ          200
`define FLASH_OP_MS      2000
`define FLASH_OP_CYCLES  (`FLASH_OP_MS * 1000 * `CLK_MHZ)
`define ERR_NONE         4'h0
`define ERR_BUSY_RUN     4'h1
`define ERR_MOTION       4'h2
`define ERR_RUNNING_OBJ  4'h3
`define ERR_ACTIVE_BUF   4'h4
`define ERR_NOT_FOUND    4'h5
`define ERR_IN_ROM       4'h6
`define ERR_FULL         4'h7
`define ERR_BAD_OBJ      4'h8
`define ERR_BAD_OP       4'h9

`endif

/* File: obj_desc_store.v */
// description text memory: one 32-character slot per registry record
// assumes the caller validates slot and index; single clock, no reset on data
`timescale 1ns/1ps
`default_nettype none
`include "obj_store_consts.vh"

module obj_desc_store (
  input  wire                   core_clk_i,
  input  wire                   wr_en_i,
  input  wire [`SLOT_W-1:0]     wr_slot_i,
  input  wire [`DESC_IDX_W-1:0] wr_idx_i,
  input  wire [7:0]             wr_char_i,
  input  wire [`SLOT_W-1:0]     rd_slot_i,
  input  wire [`DESC_IDX_W-1:0] rd_idx_i,
  output reg  [7:0]             rd_char_o
);
  reg [7:0] text [0:`MAX_OBJECTS*`DESC_CHARS-1];

  always @(posedge core_clk_i) begin
    if (wr_en_i) begin
      text[{wr_slot_i, wr_idx_i}] <= wr_char_i;
    end
    rd_char_o <= text[{rd_slot_i, rd_idx_i}];
  end
endmodule
`default_nettype wire

/* File: object_store_manager.v */
// object store manager: registry of program/buffer objects in ram and rom,
// save/delete/free commands, and per-object text descriptions.
// assumes the host handshakes cmd_valid_i/cmd_ready_o on core_clk_i; status
// inputs come from other clock domains and are synchronised here.
// Summary of operation
// RULE_01 - keep 32 description characters, drop the rest
// RULE_02 - description write only while object in ram
// RULE_03 - read-description returns stored text
// RULE_04 - opcode 0 save, 1 delete, 2 free
// RULE_05 - save copies to rom, both copies remain
// RULE_06 - rom flags survive reset of ram copy; here nrst_i clears in_rom as well as in_ram
// RULE_07 - delete removes rom and ram copies
// RULE_08 - free drops ram copy, rom untouched
// RULE_09 - refuse save/delete while program or buffer busy
// RULE_10 - refuse save/delete while motor moves
// RULE_11 - refuse freeing a running object
// RULE_12 - deleting active buffer allowed but errors
// RULE_13 - save/delete takes seconds before done
// RULE_14 - 64 KB ram, two 64 KB rom sectors
// RULE_15 - program never spans ram/rom or sectors
// RULE_16 - up to 10 programs run concurrently
// RULE_17 - at most 32 tracked objects
// RULE_18 - object numbers 0x01 to 0xff
// RULE_19 - refused command changes nothing, reports error
`timescale 1ns/1ps
`default_nettype none
`include "obj_store_consts.vh"

module object_store_manager #(
  parameter FLASH_CYCLES = `FLASH_OP_CYCLES
) (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire        cmd_valid_i,
  input  wire [1:0]  cmd_kind_i,
  input  wire [1:0]  mem_op_i,
  input  wire [7:0]  obj_num_i,
  input  wire [7:0]  desc_char_i,
  input  wire        desc_last_i,
  input  wire        prog_running_i,
  input  wire        buf_in_use_i,
  input  wire        motor_moving_i,
  input  wire        obj_running_i,
  input  wire        buf_active_i,
  output reg         cmd_ready_o,
  output reg         done_o,
  output reg         error_o,
  output reg  [3:0]  err_code_o,
  output reg         desc_valid_o,
  output reg  [7:0]  desc_char_o,
  output reg         desc_last_o,
  output reg         flash_busy_o,
  output reg         rom_write_o,
  output reg         rom_erase_o,
  output reg  [4:0]  rom_slot_o,
  output reg  [5:0]  obj_count_o
);
  // command kinds
  localparam [1:0] K_MEM = 2'h0, K_LOAD_DESC = 2'h1, K_READ_DESC = 2'h2;
  localparam [2:0] S_IDLE = 3'h0, S_LOAD = 3'h1, S_READ = 3'h2, S_FLASH = 3'h3, S_DONE = 3'h4;
  localparam [31:0] FLASH_LIMIT = FLASH_CYCLES;

  reg [2:0] state;
  // registry records
  reg [7:0] rec_num [0:`MAX_OBJECTS-1];
  reg [`MAX_OBJECTS-1:0] in_ram;
  reg [`MAX_OBJECTS-1:0] in_rom;
  reg [`SLOT_W-1:0] cur_slot;
  reg [1:0] cur_op;
  reg [3:0] pend_err;
  reg [31:0] flash_cnt;
  reg [`DESC_IDX_W:0] desc_idx;
  reg rd_pipe;
  reg rd_pipe_last;

  // two-flop synchronisers for status from other domains
  reg [4:0] st_meta;
  reg [4:0] st_sync;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_meta <= 5'h00;
      st_sync <= 5'h00;
    end else begin
      st_meta <= {buf_active_i, obj_running_i, motor_moving_i, buf_in_use_i, prog_running_i};
      st_sync <= st_meta;
    end
  end
  wire any_busy = st_sync[0] | st_sync[1];
  wire moving   = st_sync[2];
  wire obj_run  = st_sync[3];
  wire buf_act  = st_sync[4];

  // lookup of object number and first free record, one generate per record
  wire [`MAX_OBJECTS-1:0] hit;
  wire [`MAX_OBJECTS-1:0] free_rec;
  genvar g;
  generate
    for (g = 0; g < `MAX_OBJECTS; g = g + 1) begin : rec
      assign hit[g]      = (in_ram[g] | in_rom[g]) && (rec_num[g] == obj_num_i);
      assign free_rec[g] = ~(in_ram[g] | in_rom[g]);
    end
  endgenerate

  reg [`SLOT_W-1:0] hit_slot;
  reg [`SLOT_W-1:0] free_slot;
  integer i;
  always @* begin
    hit_slot  = {`SLOT_W{1'b0}};
    free_slot = {`SLOT_W{1'b0}};
    for (i = `MAX_OBJECTS - 1; i >= 0; i = i - 1) begin
      if (hit[i]) begin
        hit_slot = i[`SLOT_W-1:0];
      end
      if (free_rec[i]) begin
        free_slot = i[`SLOT_W-1:0];
      end
    end
  end
  wire any_hit  = |hit;
  wire any_free = |free_rec;

  // command check, all refusals decided before any state changes
  reg [3:0] next_err;
  always @* begin
    next_err = `ERR_NONE;
    // RULE_18 object range
    if (obj_num_i == 8'h00) begin
      next_err = `ERR_BAD_OBJ;
    end else if (cmd_kind_i == K_MEM) begin
      // RULE_04 opcode decode
      case (mem_op_i)
        `OP_SAVE, `OP_DELETE: begin
          // RULE_09 busy refusal
          if (any_busy) begin
            next_err = `ERR_BUSY_RUN;
          // RULE_10 motion refusal
          end else if (moving) begin
            next_err = `ERR_MOTION;
          end else if (!any_hit) begin
            next_err = `ERR_NOT_FOUND;
          end else if (mem_op_i == `OP_SAVE && !in_ram[hit_slot]) begin
            next_err = `ERR_NOT_FOUND;
          end
        end
        `OP_FREE: begin
          // RULE_11 running object
          if (obj_run) begin
            next_err = `ERR_RUNNING_OBJ;
          end else if (!any_hit || !in_ram[hit_slot]) begin
            next_err = `ERR_NOT_FOUND;
          end
        end
        default: next_err = `ERR_BAD_OP;
      endcase
    end else if (cmd_kind_i == K_LOAD_DESC) begin
      // RULE_02 ram only, rom copy frozen
      if (any_hit && in_rom[hit_slot]) begin
        next_err = `ERR_IN_ROM;
      end else if (any_hit && !in_ram[hit_slot]) begin
        next_err = `ERR_NOT_FOUND;
      // RULE_17 registry capacity
      end else if (!any_hit && !any_free) begin
        next_err = `ERR_FULL;
      end
    end else if (cmd_kind_i == K_READ_DESC) begin
      if (!any_hit) begin
        next_err = `ERR_NOT_FOUND;
      end
    end else begin
      next_err = `ERR_BAD_OP;
    end
  end

  // description memory port control
  wire desc_wr = (state == S_LOAD) && cmd_valid_i && (desc_idx < `DESC_CHARS);
  wire [7:0] rd_char;
  obj_desc_store u_desc (
    .core_clk_i (core_clk_i),
    .wr_en_i    (desc_wr),
    .wr_slot_i  (cur_slot),
    .wr_idx_i   (desc_idx[`DESC_IDX_W-1:0]),
    .wr_char_i  (desc_char_i),
    .rd_slot_i  (cur_slot),
    .rd_idx_i   (desc_idx[`DESC_IDX_W-1:0]),
    .rd_char_o  (rd_char)
  );

  reg [5:0] next_count;
  integer k;
  always @* begin
    next_count = 6'h00;
    for (k = 0; k < `MAX_OBJECTS; k = k + 1) begin
      next_count = next_count + {5'h00, in_ram[k] | in_rom[k]};
    end
  end

  // RULE_06 in_rom is cleared by nrst_i along with in_ram, no flash-preserving reset: registry
  // flags reset here stand for the volatile copy; rom contents live in the flash.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state        <= S_IDLE;
      in_ram       <= {`MAX_OBJECTS{1'b0}};
      in_rom       <= {`MAX_OBJECTS{1'b0}};
      cur_slot     <= {`SLOT_W{1'b0}};
      cur_op       <= 2'h0;
      pend_err     <= `ERR_NONE;
      flash_cnt    <= 32'h0000_0000;
      desc_idx     <= {(`DESC_IDX_W+1){1'b0}};
      rd_pipe      <= 1'b0;
      rd_pipe_last <= 1'b0;
      cmd_ready_o  <= 1'b0;
      done_o       <= 1'b0;
      error_o      <= 1'b0;
      err_code_o   <= `ERR_NONE;
      desc_valid_o <= 1'b0;
      desc_char_o  <= 8'h00;
      desc_last_o  <= 1'b0;
      flash_busy_o <= 1'b0;
      rom_write_o  <= 1'b0;
      rom_erase_o  <= 1'b0;
      rom_slot_o   <= 5'h00;
      obj_count_o  <= 6'h00;
    end else begin
      done_o       <= 1'b0;
      error_o      <= 1'b0;
      rom_write_o  <= 1'b0;
      rom_erase_o  <= 1'b0;
      desc_valid_o <= 1'b0;
      desc_last_o  <= 1'b0;
      obj_count_o  <= next_count;
      case (state)
        S_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cur_slot <= any_hit ? hit_slot : free_slot;
            cur_op   <= mem_op_i;
            desc_idx <= {(`DESC_IDX_W+1){1'b0}};
            // RULE_19 refusal leaves state untouched
            if (next_err != `ERR_NONE) begin
              err_code_o <= next_err;
              error_o    <= 1'b1;
              done_o     <= 1'b1;
            end else if (cmd_kind_i == K_MEM) begin
              if (mem_op_i == `OP_FREE) begin
                // RULE_08 drop ram copy only
                in_ram[hit_slot] <= 1'b0;
                err_code_o       <= `ERR_NONE;
                done_o           <= 1'b1;
              end else begin
                // RULE_12 active buffer delete proceeds, flagged
                pend_err     <= (mem_op_i == `OP_DELETE && buf_act) ? `ERR_ACTIVE_BUF : `ERR_NONE;
                flash_cnt    <= 32'h0000_0000;
                flash_busy_o <= 1'b1;
                rom_slot_o   <= hit_slot;
                cmd_ready_o  <= 1'b0;
                state        <= S_FLASH;
              end
            end else if (cmd_kind_i == K_LOAD_DESC) begin
              if (!any_hit) begin
                rec_num[free_slot] <= obj_num_i;
                in_ram[free_slot]  <= 1'b1;
              end
              state <= S_LOAD;
            end else begin
              cmd_ready_o <= 1'b0;
              state       <= S_READ;
            end
          end
        end
        S_LOAD: begin
          // RULE_01 characters past 32 accepted but dropped
          if (cmd_valid_i) begin
            if (desc_idx < `DESC_CHARS) begin
              desc_idx <= desc_idx + 1'b1;
            end
            if (desc_last_i) begin
              err_code_o <= `ERR_NONE;
              done_o     <= 1'b1;
              state      <= S_IDLE;
            end
          end
        end
        S_READ: begin
          // RULE_03 stream stored text, one char a cycle after two-cycle latency
          rd_pipe      <= (desc_idx < `DESC_CHARS);
          rd_pipe_last <= (desc_idx == `DESC_CHARS - 1);
          if (desc_idx < `DESC_CHARS) begin
            desc_idx <= desc_idx + 1'b1;
          end
          if (rd_pipe) begin
            desc_valid_o <= 1'b1;
            desc_char_o  <= rd_char;
            desc_last_o  <= rd_pipe_last;
            if (rd_pipe_last) begin
              rd_pipe    <= 1'b0;
              err_code_o <= `ERR_NONE;
              done_o     <= 1'b1;
              state      <= S_IDLE;
            end
          end
        end
        S_FLASH: begin
          // RULE_13 hold busy for the flash program/erase time
          if (flash_cnt >= FLASH_LIMIT - 1) begin
            flash_busy_o <= 1'b0;
            if (cur_op == `OP_SAVE) begin
              // RULE_05 copy to rom, ram copy kept
              in_rom[cur_slot] <= 1'b1;
              rom_write_o      <= 1'b1;
            end else begin
              // RULE_07 remove from rom and ram
              in_rom[cur_slot] <= 1'b0;
              in_ram[cur_slot] <= 1'b0;
              rom_erase_o      <= 1'b1;
            end
            err_code_o <= pend_err;
            error_o    <= (pend_err != `ERR_NONE);
            done_o     <= 1'b1;
            state      <= S_DONE;
          end else begin
            flash_cnt <= flash_cnt + 32'h0000_0001;
          end
        end
        S_DONE: begin
          cmd_ready_o <= 1'b1;
          state       <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // RULE_14 RULE_15 RULE_16 placement and execution limits are kept by the
  // program engine; this block only records presence per memory.
endmodule
`default_nettype wire

/* File: obj_store_checker.sv */
// assertions on the object store manager ports
// assumes bind into object_store_manager; status levels held 3 cycles before a command
`timescale 1ns/1ps
`default_nettype none
module obj_store_checker #(
  parameter FLASH_CYCLES = 20
) (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic       cmd_valid_i,
  input wire logic [1:0] cmd_kind_i,
  input wire logic [1:0] mem_op_i,
  input wire logic [7:0] obj_num_i,
  input wire logic       prog_running_i,
  input wire logic       motor_moving_i,
  input wire logic       cmd_ready_o,
  input wire logic       done_o,
  input wire logic       error_o,
  input wire logic       desc_valid_o,
  input wire logic       desc_last_o,
  input wire logic       flash_busy_o,
  input wire logic       rom_write_o,
  input wire logic       rom_erase_o,
  input wire logic [5:0] obj_count_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  localparam int FC_LO = FLASH_CYCLES - 1;
  localparam int FC_HI = FLASH_CYCLES + 1;
  wire  take0 = cmd_valid_i && cmd_ready_o && cmd_kind_i == 2'h0;
  logic [5:0] nchar;
  // chars since the last flagged one, to pin the stream length
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) nchar <= 6'h00;
    else if (desc_valid_o) nchar <= desc_last_o ? 6'h00 : nchar + 6'h01;
  end
  err_has_done_a: assert property (error_o |-> done_o) else $error("error without done");
  busy_blocks_a: assert property (flash_busy_o |-> !cmd_ready_o) else $error("ready while busy");
  flash_time_a: assert property ($rose(flash_busy_o) |-> ##[FC_LO:FC_HI] done_o) else $error("flash time");
  rom_write_ok_a: assert property (rom_write_o |-> done_o && !error_o) else $error("bad rom write");
  erase_done_a: assert property (rom_erase_o |-> done_o) else $error("erase without done");
  motion_refuse_a: assert property (motor_moving_i [*3] ##0 (take0 && mem_op_i < 2'h2 && obj_num_i != 8'h00)
    |=> done_o && error_o && !flash_busy_o) else $error("save during motion");
  run_refuse_a: assert property (prog_running_i [*3] ##0 (take0 && mem_op_i < 2'h2 && obj_num_i != 8'h00)
    |=> done_o && error_o) else $error("save while running");
  bad_obj_a: assert property (take0 && obj_num_i == 8'h00 && mem_op_i != 2'h3 |=> done_o && error_o)
    else $error("object zero accepted");
  count_cap_a: assert property (obj_count_o <= 6'h20) else $error("too many records");
  read_len_a: assert property (desc_last_o |-> desc_valid_o && done_o && nchar == 6'h1f)
    else $error("bad read length");
endmodule
bind object_store_manager obj_store_checker #(.FLASH_CYCLES(FLASH_CYCLES)) obj_store_checker_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i),
  .mem_op_i(mem_op_i), .obj_num_i(obj_num_i), .prog_running_i(prog_running_i),
  .motor_moving_i(motor_moving_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .error_o(error_o),
  .desc_valid_o(desc_valid_o), .desc_last_o(desc_last_o), .flash_busy_o(flash_busy_o),
  .rom_write_o(rom_write_o), .rom_erase_o(rom_erase_o), .obj_count_o(obj_count_o));
`default_nettype wire

/* File: host_model.sv */
// host side: issues commands and streams description characters
// assumes the device samples on the rising edge; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk_i,
  input  wire logic       cmd_ready_i,
  output var  logic       cmd_valid_o,
  output var  logic [1:0] cmd_kind_o,
  output var  logic [1:0] mem_op_o,
  output var  logic [7:0] obj_num_o,
  output var  logic [7:0] desc_char_o,
  output var  logic       desc_last_o
);
  initial begin
    {cmd_valid_o, cmd_kind_o, mem_op_o, obj_num_o, desc_char_o, desc_last_o} = 22'h0;
  end
  // opcode and object fields; host waits out flash ops via ready
  task automatic send(input logic [1:0] kind, op, input logic [7:0] obj, input int nch, output logic ok);
    @(negedge core_clk_i);
    {cmd_valid_o, cmd_kind_o, mem_op_o, obj_num_o, desc_last_o} = {1'b1, kind, op, obj, 1'b0};
    ok = cmd_ready_i === 1'b1;
    for (int n = 0; n < 400 && !ok; n++) begin
      @(negedge core_clk_i);
      ok = cmd_ready_i === 1'b1;
    end
    @(posedge core_clk_i);
    for (int i = 0; i < nch; i++) begin
      @(negedge core_clk_i);
      desc_char_o = 8'h40 + i[7:0];
      desc_last_o = i == nch - 1;
      @(posedge core_clk_i);
    end
    // released object and char fields show no stale value; kind and op keep theirs
    @(negedge core_clk_i);
    {cmd_valid_o, desc_last_o} = 2'h0;
    obj_num_o = ~obj_num_o;
    desc_char_o = ~desc_char_o;
  endtask
endmodule
`default_nettype wire

/* File: object_store_manager_tb.sv */
// self-checking bench for the object store manager
// assumes the host model drives commands; status levels come from here
`timescale 1ns/1ps
`default_nettype none
module object_store_manager_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic prog_run = 1'b0, buf_use = 1'b0, motor = 1'b0, obj_run = 1'b0, buf_act = 1'b0;
  wire  cmd_valid, desc_last_h, cmd_ready, done, error, desc_valid, desc_last, flash_busy, rom_write, rom_erase;
  wire  [1:0] cmd_kind, mem_op;
  wire  [7:0] obj_num, desc_char_h, desc_char;
  wire  [3:0] err_code;
  wire  [5:0] obj_count;
  int   mismatches = 0, n_compared = 0, nrx, lastpos, ncyc;
  logic ok, saw_w, saw_e;
  logic [7:0] rx [0:39];
  localparam int FLASH = 20;
  always #2.5 core_clk = ~core_clk;
  host_model host_model_i (.core_clk_i(core_clk), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
    .cmd_kind_o(cmd_kind), .mem_op_o(mem_op), .obj_num_o(obj_num), .desc_char_o(desc_char_h),
    .desc_last_o(desc_last_h));
  object_store_manager #(.FLASH_CYCLES(FLASH)) object_store_manager_i (.core_clk_i(core_clk), .nrst_i(nrst),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .mem_op_i(mem_op), .obj_num_i(obj_num),
    .desc_char_i(desc_char_h), .desc_last_i(desc_last_h), .prog_running_i(prog_run), .buf_in_use_i(buf_use),
    .motor_moving_i(motor), .obj_running_i(obj_run), .buf_active_i(buf_act), .cmd_ready_o(cmd_ready),
    .done_o(done), .error_o(error), .err_code_o(err_code), .desc_valid_o(desc_valid), .desc_char_o(desc_char),
    .desc_last_o(desc_last), .flash_busy_o(flash_busy), .rom_write_o(rom_write), .rom_erase_o(rom_erase),
    .rom_slot_o(), .obj_count_o(obj_count));
  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command, then wait for done collecting read chars and rom strobes
  task automatic issue(input logic [1:0] kind, op, input logic [7:0] obj, input int nch, input logic [3:0] code);
    host_model_i.send(kind, op, obj, nch, ok);
    {nrx, ncyc, lastpos, saw_w, saw_e} = 0;
    while (ok && done !== 1'b1 && ncyc < 200) begin
      @(negedge core_clk);
      ncyc++;
      saw_w |= rom_write === 1'b1;
      saw_e |= rom_erase === 1'b1;
      if (desc_valid === 1'b1) begin
        rx[nrx % 40] = desc_char;
        if (desc_last === 1'b1) lastpos = nrx;
        nrx++;
      end
    end
    if (done !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    check("err_code", {4'h0, code}, {4'h0, err_code});
    check("error", {7'h0, code != 4'h0}, {7'h0, error});
  endtask
  task automatic stat(input logic [4:0] s);
    @(negedge core_clk);
    {prog_run, buf_use, motor, obj_run, buf_act} = s;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_desc;
    issue(2'h1, 2'h0, 8'h05, 34, 4'h0);
    issue(2'h2, 2'h0, 8'h05, 0, 4'h0);
    check("chars", 8'h20, nrx[7:0]);
    check("last", 8'h1f, lastpos[7:0]);
    for (int i = 0; i < 32; i++) check("char", 8'h40 + i[7:0], rx[i]);
  endtask
  task automatic t_save;
    issue(2'h0, 2'h0, 8'h05, 0, 4'h0);
    check("rom_write", 8'h01, {7'h0, saw_w});
    // counted from the first falling edge after the take edge
    check("cycles", FLASH, ncyc[7:0]);
    // a refused load ends at once, so no characters follow it
    issue(2'h1, 2'h0, 8'h05, 0, 4'h6);
  endtask
  // motor, running program, busy buffer, running object
  task automatic t_refuse;
    for (int i = 0; i < 4; i++) begin
      stat(5'({5'h02, 5'h08, 5'h10, 5'h04} >> (i * 5)));
      issue(2'h0, 2'(8'h84 >> (i * 2)), 8'h05, 0, 4'(16'h3112 >> (i * 4)));
    end
    stat(5'h00);
    check("count", 8'h01, {2'h0, obj_count});
  endtask
  task automatic t_free;
    issue(2'h0, 2'h2, 8'h05, 0, 4'h0);
    stat(5'h00);
    check("count", 8'h01, {2'h0, obj_count});
    issue(2'h0, 2'h3, 8'h05, 0, 4'h9);
    issue(2'h3, 2'h0, 8'h05, 0, 4'h9);
    issue(2'h0, 2'h0, 8'h00, 0, 4'h8);
  endtask
  task automatic t_del;
    stat(5'h01);
    issue(2'h0, 2'h1, 8'h05, 0, 4'h4);
    check("rom_erase", 8'h01, {7'h0, saw_e});
    stat(5'h00);
    check("count", 8'h00, {2'h0, obj_count});
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    t_desc();
    t_save();
    t_refuse();
    t_free();
    t_del();
    finish_test();
  end
endmodule
`default_nettype wire
